// ### rtl/i2c_regacc_pkg.sv
package i2c_regacc_pkg;

	localparam logic [6:0] MAIN_ADDR_DFLT = 7'h15;
	localparam logic [6:0] FG_ADDR_DFLT   = 7'h36;
	localparam logic [6:0] RAM_ADDR_DFLT  = 7'h55;
	// high-speed master code 0000_1xxx
	localparam logic [4:0] HS_CODE        = 5'h01;
	localparam logic [7:0] GEN_CALL       = 8'h00;
	localparam logic [7:0] PTR_TOP        = 8'hff;
	localparam logic [7:0] PTR_STEP       = 8'h01;
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	localparam logic [3:0] TX_LAST_BIT    = 4'h7;

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_IGNORE} phase_e;
	typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} kind_e;
	typedef enum logic [1:0] {B_MAIN, B_FG, B_RAM} blk_e;

	typedef struct packed {
		logic        en;
		blk_e        blk;
		logic [7:0]  addr;
		logic [15:0] data;
	} wr_s;

	typedef struct packed {
		phase_e      st;
		kind_e       kind;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic        rw;
		logic        acked;
		blk_e        blk;
		logic [7:0]  ptr;
		logic        top;
		logic        hi;
		logic [7:0]  lo;
		logic        sda_oe;
		logic        sda_o;
		logic        scl_q;
		logic        sda_q;
		logic        hs;
		wr_s         wr;
	} state_s;

endpackage

// ### rtl/i2c_regacc_slave.sv
`timescale 1ns/1ps
// Functional notes
// - word writes cover fuel-gauge addresses 00h..FFh, writable as one block
// - word write takes low byte first, then high byte; assembled in that order
// - word address advances by one after each complete 16-bit word
// - data beyond address FFh is discarded, never wrapped
// - writes to read-only locations discarded; reserved locations still written
// - read: address+write, pointer, repeated start, address+read; each acknowledged
// - on address match pull data low at acknowledge, then send the eight bits of the register at the pointer
// - controller acknowledge of read byte makes device send next register
// - stop keeps register pointer; later read without pointer uses it
// - stop restores low-speed filters; repeated start keeps current filter setting
// - every pointer value is acknowledged, present register or not
// - never stretch clock; general call address not acknowledged
// - three 7-bit target addresses: main, fuel gauge words, RAM bytes
module i2c_regacc_slave
	import i2c_regacc_pkg::*;
#(
	parameter logic [6:0] MAIN_ADDR = MAIN_ADDR_DFLT,
	parameter logic [6:0] FG_ADDR   = FG_ADDR_DFLT,
	parameter logic [6:0] RAM_ADDR  = RAM_ADDR_DFLT
) (
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_srst,
	// bus pins; scl is input only, so the clock is never stretched
	input  wire logic                  i_scl,
	input  wire logic                  i_sda,
	output logic                       o_sda,
	output logic                       o_sda_oe,
	// register space
	output i2c_regacc_pkg::blk_e       o_blk,
	output logic [7:0]                 o_ptr,
	input  wire logic [7:0]            i_rd_data,
	input  wire logic                  i_ptr_ro,
	output i2c_regacc_pkg::wr_s        o_wr,
	// filter select
	output logic                       o_hs_filter
);
	import i2c_regacc_pkg::*;

	state_s s;
	state_s next_s;
	logic   scl_rise;
	logic   scl_fall;
	logic   start_c;
	logic   stop_c;

	assign scl_rise = i_scl && !s.scl_q;
	assign scl_fall = !i_scl && s.scl_q;
	assign start_c  = i_scl && s.scl_q && s.sda_q && !i_sda;
	assign stop_c   = i_scl && s.scl_q && !s.sda_q && i_sda;

	always_comb begin
		next_s        = s;
		next_s.scl_q  = i_scl;
		next_s.sda_q  = i_sda;
		next_s.sda_o  = 1'b0;
		next_s.wr.en  = 1'b0;
		if (stop_c) begin
			next_s.st     = ST_IDLE;
			next_s.sda_oe = 1'b0;
			next_s.hs     = 1'b0;
		end else if (start_c) begin
			// repeated start leaves hs and ptr alone
			next_s.st     = ST_RX;
			next_s.kind   = K_ADDR;
			next_s.cnt    = 4'h0;
			next_s.sda_oe = 1'b0;
			next_s.hi     = 1'b0;
		end else begin
			case (s.st)
				ST_RX: begin
					if (scl_rise) begin
						next_s.sh  = {s.sh[6:0], i_sda};
						next_s.cnt = s.cnt + 4'h1;
					end else if (scl_fall && s.cnt == BITS_PER_BYTE) begin
						next_s.st     = ST_ACK;
						next_s.sda_oe = 1'b1;
						case (s.kind)
							K_ADDR: begin
								next_s.rw = s.sh[0];
								if (s.sh[7:1] == MAIN_ADDR) begin
									next_s.blk = B_MAIN;
								end else if (s.sh[7:1] == FG_ADDR) begin
									next_s.blk = B_FG;
								end else if (s.sh[7:1] == RAM_ADDR) begin
									next_s.blk = B_RAM;
								end else begin
									// mismatch, general call, or hs code
									next_s.st     = ST_IGNORE;
									next_s.sda_oe = 1'b0;
									if (s.sh[7:3] == HS_CODE) begin
										next_s.hs = 1'b1;
									end
								end
							end
							K_PTR: begin
								next_s.ptr = s.sh;
								next_s.top = 1'b0;
								next_s.hi  = 1'b0;
							end
							default: begin
								if (s.blk == B_FG && !s.hi) begin
									next_s.lo = s.sh;
									next_s.hi = 1'b1;
								end else begin
									next_s.hi = 1'b0;
									if (!s.top) begin
										// word done: write unless read-only, then advance
										next_s.wr.en   = !i_ptr_ro;
										next_s.wr.blk  = s.blk;
										next_s.wr.addr = s.ptr;
										next_s.wr.data = (s.blk == B_FG) ?
											{s.sh, s.lo} : {8'h00, s.sh};
										next_s.ptr     = s.ptr + PTR_STEP;
										next_s.top     = (s.ptr == PTR_TOP);
									end
								end
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						next_s.cnt = 4'h0;
						if (s.kind == K_ADDR && s.rw) begin
							next_s.st     = ST_TX;
							next_s.sh     = i_rd_data;
							next_s.sda_oe = !i_rd_data[7];
						end else begin
							next_s.st     = ST_RX;
							next_s.sda_oe = 1'b0;
							next_s.kind   = (s.kind == K_ADDR) ? K_PTR : K_DATA;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (s.cnt == TX_LAST_BIT) begin
							next_s.st     = ST_MACK;
							next_s.sda_oe = 1'b0;
						end else begin
							next_s.sh     = {s.sh[6:0], 1'b0};
							next_s.sda_oe = !s.sh[6];
							next_s.cnt    = s.cnt + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						next_s.acked = !i_sda;
						if (!i_sda) begin
							next_s.ptr = s.ptr + PTR_STEP;
						end
					end else if (scl_fall) begin
						if (s.acked) begin
							next_s.st     = ST_TX;
							next_s.cnt    = 4'h0;
							next_s.sh     = i_rd_data;
							next_s.sda_oe = !i_rd_data[7];
						end else begin
							next_s.st = ST_IGNORE;
						end
					end
				end
				default: begin
					next_s.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s <= '0;
			s.st    <= ST_IDLE;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign o_sda       = s.sda_o;
	assign o_sda_oe    = s.sda_oe;
	assign o_blk       = s.blk;
	assign o_ptr       = s.ptr;
	assign o_wr        = s.wr;
	assign o_hs_filter = s.hs;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	a_ignore_no_drive: assert property ((s.st == ST_IGNORE || s.st == ST_IDLE) |-> !s.sda_oe)
		else $error("data line driven while ignoring");
	a_stop_filter_low: assert property (stop_c |=> !s.hs)
		else $error("stop did not restore filters");
	a_restart_keeps_hs: assert property (start_c && !stop_c |=> s.hs == $past(s.hs))
		else $error("repeated start changed filters");
	a_stop_keeps_ptr: assert property (stop_c |=> s.ptr == $past(s.ptr))
		else $error("stop changed pointer");
	a_ptr_always_acked: assert property (!start_c && !stop_c && s.st == ST_RX && s.kind == K_PTR
		&& s.cnt == BITS_PER_BYTE && scl_fall |=> s.sda_oe && s.st == ST_ACK)
		else $error("pointer not acknowledged");
	a_gencall_nack: assert property (!start_c && !stop_c && s.st == ST_RX && s.kind == K_ADDR
		&& s.cnt == BITS_PER_BYTE && s.sh == GEN_CALL && scl_fall |=> !s.sda_oe)
		else $error("general call acknowledged");
	a_word_advance: assert property (s.wr.en |-> s.top || s.ptr == s.wr.addr + PTR_STEP)
		else $error("word address not advanced");
	a_word_order: assert property (s.wr.en && s.wr.blk == B_FG |-> s.wr.data[7:0] == s.lo)
		else $error("word byte order wrong");
	a_past_top_drop: assert property (s.top && s.st == ST_RX |-> !s.wr.en)
		else $error("write beyond top address");
	a_ro_drop: assert property (!start_c && !stop_c && s.st == ST_RX && s.kind == K_DATA
		&& s.cnt == BITS_PER_BYTE && scl_fall && i_ptr_ro |=> !s.wr.en)
		else $error("read-only location written");
	a_seq_advance: assert property (!start_c && !stop_c && s.st == ST_MACK && scl_rise && !i_sda
		|=> s.ptr == $past(s.ptr) + PTR_STEP)
		else $error("sequential read did not advance");
	a_tx_bit: assert property (s.st == ST_TX |-> s.sda_oe == !s.sh[7])
		else $error("transmitted bit wrong");

	c_word_write: cover property (s.wr.en && s.wr.blk == B_FG);
	c_seq_read: cover property (s.st == ST_MACK && s.acked ##1 s.st == ST_TX);
	c_past_top: cover property (s.top && s.st == ST_RX);
	c_hs_mode: cover property (s.hs);

endmodule // i2c_regacc_slave

// ### sim/i2c_ctrl_model.sv
`timescale 1ns/1ps
module i2c_ctrl_model #(
	parameter int Q = 4
) (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oe
);
	initial begin
		o_scl <= 1'b1;
		o_sda_oe <= 1'b0;
	end
	task automatic w();
		repeat (Q) @(posedge i_clk);
	endtask
	// also serves as repeated start
	task automatic start();
		o_sda_oe <= 1'b0;
		w();
		o_scl <= 1'b1;
		w();
		o_sda_oe <= 1'b1;
		w();
		o_scl <= 1'b0;
		w();
	endtask
	task automatic stop();
		o_sda_oe <= 1'b1;
		w();
		o_scl <= 1'b1;
		w();
		o_sda_oe <= 1'b0;
		w();
	endtask
	task automatic bit_io(input logic b, output logic r);
		o_sda_oe <= ~b;
		w();
		o_scl <= 1'b1;
		w();
		r = i_sda;
		w();
		o_scl <= 1'b0;
		w();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(~ack, r);
	endtask
endmodule // i2c_ctrl_model

// ### sim/i2c_register_access_slave_tb_top.sv
`timescale 1ns/1ps
`define M u_i2c_ctrl_model
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("mismatch at %0t: %h %h", $time, a, b); end end
module i2c_register_access_slave_tb_top;
	import i2c_regacc_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        scl, m_oe, sda_oe, sda_o, hs, ack, ro;
	wire logic   sda;
	blk_e        blk;
	logic [7:0]  ptr, d, rd;
	logic [15:0] w [3];
	logic [7:0]  mem [3][256];
	wr_s         wr;
	wr_s         got[$], exp_q[$];
	int          n_errors = 0, checked = 0, cyc = 0;
	// open drain with pull-up
	assign sda = ~((sda_oe & ~sda_o) | m_oe);
	assign rd = mem[blk][ptr];
	assign ro = (ptr == 8'h40);
	initial forever #12.5 clk = ~clk;
	i2c_regacc_slave u_i2c_regacc_slave (.i_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda),
		.o_sda(sda_o), .o_sda_oe(sda_oe), .o_blk(blk), .o_ptr(ptr), .i_rd_data(rd),
		.i_ptr_ro(ro), .o_wr(wr), .o_hs_filter(hs));
	i2c_ctrl_model u_i2c_ctrl_model (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
	task automatic give_verdict();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wr.en === 1'b1) got.push_back(wr);
		if (cyc == 30000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic wb(input logic [7:0] v, input logic e);
		`M.wbyte(v, ack);
		`CHK(ack, e)
	endtask
	task automatic rb(input logic a, input int p);
		`M.rbyte(a, d);
		`CHK(d, mem[B_MAIN][p])
	endtask
	initial begin
		void'($urandom(32'h9b6a3227));
		foreach (mem[b, p]) mem[b][p] = 8'($urandom);
		foreach (w[i]) w[i] = 16'($urandom);
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		// word writes running past the top
		`M.start();
		wb(8'h6c, 1'b1);
		wb(8'hfe, 1'b1);
		for (int i = 0; i < 3; i++) begin
			wb(w[i][7:0], 1'b1);
			wb(w[i][15:8], 1'b1);
		end
		`M.stop();
		exp_q.push_back('{1'b1, B_FG, 8'hfe, w[0]});
		exp_q.push_back('{1'b1, B_FG, 8'hff, w[1]});
		// bytes across a read-only location
		`M.start();
		wb(8'h2a, 1'b1);
		wb(8'h3f, 1'b1);
		for (int i = 0; i < 3; i++) wb(w[i][7:0], 1'b1);
		`M.stop();
		exp_q.push_back('{1'b1, B_MAIN, 8'h3f, {8'h00, w[0][7:0]}});
		exp_q.push_back('{1'b1, B_MAIN, 8'h41, {8'h00, w[2][7:0]}});
		`M.start();
		wb(8'haa, 1'b1);
		wb(8'h10, 1'b1);
		wb(w[0][15:8], 1'b1);
		`M.stop();
		exp_q.push_back('{1'b1, B_RAM, 8'h10, {8'h00, w[0][15:8]}});
		`CHK(blk, B_RAM)
		// pointer phase, repeated start, sequential read
		`M.start();
		wb(8'h2a, 1'b1);
		wb(8'h20, 1'b1);
		`M.start();
		wb(8'h2b, 1'b1);
		rb(1'b1, 8'h20);
		rb(1'b1, 8'h21);
		rb(1'b0, 8'h22);
		`M.stop();
		`M.start();
		wb(8'h2b, 1'b1);
		rb(1'b0, 8'h22);
		`M.stop();
		`CHK(ptr, 8'h22)
		// general call and foreign address
		`M.start();
		wb(8'h00, 1'b0);
		`M.stop();
		`M.start();
		wb(8'h66, 1'b0);
		wb(8'h2a, 1'b0);
		`M.stop();
		// filter select
		`M.start();
		wb(8'h08, 1'b0);
		`CHK(hs, 1'b1)
		`M.start();
		`CHK(hs, 1'b1)
		wb(8'h2a, 1'b1);
		wb(8'h00, 1'b1);
		`M.stop();
		`CHK(hs, 1'b0)
		`CHK(sda_o, 1'b0)
		`CHK(got.size(), exp_q.size())
		foreach (exp_q[i]) `CHK(got[i], exp_q[i])
		give_verdict();
	end
endmodule // i2c_register_access_slave_tb_top
